/* hdl/arf_pkg.sv */
package arf_pkg;
  // ==========================================================
  // register map (special-function-register space)
  localparam logic [7:0] ARF_ADDR_RESULT_LOW = 8'hBD;
  localparam logic [7:0] ARF_ADDR_RESULT_HIGH = 8'hBE;
  localparam logic [7:0] ARF_RESULT_RESET = 8'h00;
  // ==========================================================
  // result word layout
  localparam int ARF_RAW_WIDTH = 10;
  localparam int ARF_BYTE_WIDTH = 8;
  localparam logic [7:0] ARF_ZERO_BYTE = 8'h00;
  localparam logic [5:0] ARF_ZERO_PAD = 6'h00;
endpackage

/* hdl/arf_align.sv */
`timescale 1ns/1ns
`default_nettype none
module arf_align
  import arf_pkg::*;
(
  input wire logic [ARF_RAW_WIDTH-1:0] i_raw, // raw converter word
  input wire logic i_left_justify_select, // 1 = left aligned
  input wire logic i_eight_bit_mode, // 1 = 8-bit conversion
  output logic [ARF_BYTE_WIDTH-1:0] o_high, // formatted high byte
  output logic [ARF_BYTE_WIDTH-1:0] o_low // formatted low byte
);
  // ==========================================================
  // justification steering
  always_comb begin
    if (i_eight_bit_mode) begin
      o_high = i_raw[ARF_BYTE_WIDTH-1:0];
      o_low = ARF_ZERO_BYTE;
    end else if (i_left_justify_select) begin
      o_high = i_raw[ARF_RAW_WIDTH-1:2];
      o_low = {i_raw[1:0], ARF_ZERO_PAD};
    end else begin
      o_high = {ARF_ZERO_PAD, i_raw[ARF_RAW_WIDTH-1:ARF_BYTE_WIDTH]};
      o_low = i_raw[ARF_BYTE_WIDTH-1:0];
    end
  end
endmodule
`default_nettype wire

/* hdl/arf_result_formatter.sv */
// Operation
// - right justify: high byte zeros, top two bits
// - left justify: high byte holds top eight bits
// - 8-bit mode: high byte holds whole result
// - right justify: low byte holds low eight
// - left justify: low bits 7:6, rest zero
// - 8-bit mode: low byte reads zero
`timescale 1ns/1ns
`default_nettype none
module arf_result_formatter
  import arf_pkg::*;
(
  input wire logic I_CLK, // system clock, 50 MHz
  input wire logic I_RST_B, // async reset, active low
  input wire logic [ARF_RAW_WIDTH-1:0] I_RAW, // raw result from converter core
  input wire logic I_DONE, // one-cycle conversion complete pulse
  input wire logic I_LEFT_JUSTIFY_SELECT, // justification select
  input wire logic I_EIGHT_BIT_MODE, // 8-bit conversion mode
  input wire logic I_SFR_WR, // register write strobe
  input wire logic [7:0] I_SFR_ADDR, // register address
  input wire logic [7:0] I_SFR_WDATA, // register write data
  output logic [ARF_BYTE_WIDTH-1:0] O_RESULT_HIGH, // high result byte
  output logic [ARF_BYTE_WIDTH-1:0] O_RESULT_LOW // low result byte
);
  typedef struct packed {
    logic [ARF_BYTE_WIDTH-1:0] high_ff;
    logic [ARF_BYTE_WIDTH-1:0] low_ff;
  } arf_state_t;

  arf_state_t cur_ff;
  arf_state_t nxt_cur;
  logic [ARF_BYTE_WIDTH-1:0] fmt_high;
  logic [ARF_BYTE_WIDTH-1:0] fmt_low;
  logic wr_high;
  logic wr_low;

  // bits of the raw word that spill past one byte
  localparam int ARF_SPILL = ARF_RAW_WIDTH - ARF_BYTE_WIDTH;

  // ==========================================================
  // address decode, shared by both byte registers
  // one compare per register keeps the two strobes exclusive
  function automatic logic arf_hit(input logic [7:0] addr, input logic [7:0] target);
    arf_hit = (addr == target);
  endfunction

  // write strobes per byte; any other address is ignored
  assign wr_high = I_SFR_WR && arf_hit(I_SFR_ADDR, ARF_ADDR_RESULT_HIGH);
  assign wr_low = I_SFR_WR && arf_hit(I_SFR_ADDR, ARF_ADDR_RESULT_LOW);

  // ==========================================================
  // formatting of the raw word
  arf_align u_align (
    .i_raw(I_RAW),
    .i_left_justify_select(I_LEFT_JUSTIFY_SELECT),
    .i_eight_bit_mode(I_EIGHT_BIT_MODE),
    .o_high(fmt_high),
    .o_low(fmt_low)
  );

  // ==========================================================
  // next state: completion beats software write
  always_comb begin
    nxt_cur = cur_ff;
    if (I_DONE) begin
      nxt_cur.high_ff = fmt_high;
      nxt_cur.low_ff = fmt_low;
    end else if (I_SFR_WR) begin
      if (wr_high) begin
        nxt_cur.high_ff = I_SFR_WDATA;
      end
      if (wr_low) begin
        nxt_cur.low_ff = I_SFR_WDATA;
      end
    end
  end

  // state register
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cur_ff <= '{high_ff: ARF_RESULT_RESET, low_ff: ARF_RESULT_RESET};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign O_RESULT_HIGH = cur_ff.high_ff;
  assign O_RESULT_LOW = cur_ff.low_ff;

  // ==========================================================
  // checks
  right_high_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_DONE && !I_EIGHT_BIT_MODE && !I_LEFT_JUSTIFY_SELECT |=> O_RESULT_HIGH == {6'h00, $past(I_RAW[9:8])})
    else $error("right justified high byte wrong");
  left_high_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_DONE && !I_EIGHT_BIT_MODE && I_LEFT_JUSTIFY_SELECT |=> O_RESULT_HIGH == $past(I_RAW[9:2]))
    else $error("left justified high byte wrong");
  eight_high_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_DONE && I_EIGHT_BIT_MODE |=> O_RESULT_HIGH == $past(I_RAW[7:0]))
    else $error("8-bit high byte wrong");
  right_low_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_DONE && !I_EIGHT_BIT_MODE && !I_LEFT_JUSTIFY_SELECT |=> O_RESULT_LOW == $past(I_RAW[7:0]))
    else $error("right justified low byte wrong");
  left_low_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_DONE && !I_EIGHT_BIT_MODE && I_LEFT_JUSTIFY_SELECT |=> O_RESULT_LOW == {$past(I_RAW[1:0]), 6'h00})
    else $error("left justified low byte wrong");
  eight_low_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_DONE && I_EIGHT_BIT_MODE |=> O_RESULT_LOW == 8'h00)
    else $error("8-bit low byte not zero");
  pair_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !I_DONE && !I_SFR_WR |=> $stable(O_RESULT_HIGH) && $stable(O_RESULT_LOW))
    else $error("result bytes changed without cause");

  // ==========================================================
  // capture and write path checks
  // completion loads both bytes from one formatted word
  pair_load_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_DONE
    |=> O_RESULT_HIGH == $past(fmt_high) && O_RESULT_LOW == $past(fmt_low))
    else $error("result pair not loaded together");

  // a write colliding with completion is dropped
  done_wins_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_DONE && I_SFR_WR
    |=> O_RESULT_HIGH == $past(fmt_high) && O_RESULT_LOW == $past(fmt_low))
    else $error("colliding write not dropped");

  // software write lands in the high byte
  write_high_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !I_DONE && wr_high
    |=> O_RESULT_HIGH == $past(I_SFR_WDATA))
    else $error("high byte write lost");

  // software write lands in the low byte
  write_low_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !I_DONE && wr_low
    |=> O_RESULT_LOW == $past(I_SFR_WDATA))
    else $error("low byte write lost");

  // a low byte write leaves the high byte alone
  high_keeps_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !I_DONE && wr_low
    |=> $stable(O_RESULT_HIGH))
    else $error("high byte hit by low write");

  // a high byte write leaves the low byte alone
  low_keeps_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !I_DONE && wr_high
    |=> $stable(O_RESULT_LOW))
    else $error("low byte hit by high write");

  // writes to other addresses change nothing
  stray_write_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !I_DONE && I_SFR_WR && !wr_high && !wr_low
    |=> $stable(O_RESULT_HIGH) && $stable(O_RESULT_LOW))
    else $error("stray write changed a byte");

  // ==========================================================
  // formatting checks on the aligned word
  // right justified high byte is padded with zeros
  right_pad_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !I_EIGHT_BIT_MODE && !I_LEFT_JUSTIFY_SELECT
    |-> fmt_high[ARF_BYTE_WIDTH-1:ARF_SPILL] == ARF_ZERO_PAD)
    else $error("right justified pad not zero");

  // right justified high byte carries the top bits
  right_top_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !I_EIGHT_BIT_MODE && !I_LEFT_JUSTIFY_SELECT
    |-> fmt_high[ARF_SPILL-1:0] == I_RAW[ARF_RAW_WIDTH-1:ARF_BYTE_WIDTH])
    else $error("right justified top bits wrong");

  // left justified high byte carries the upper eight bits
  left_word_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !I_EIGHT_BIT_MODE && I_LEFT_JUSTIFY_SELECT
    |-> fmt_high == I_RAW[ARF_RAW_WIDTH-1:ARF_SPILL])
    else $error("left justified word wrong");

  // 8-bit mode ignores the justification select
  eight_word_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_EIGHT_BIT_MODE
    |-> fmt_high == I_RAW[ARF_BYTE_WIDTH-1:0])
    else $error("8-bit word wrong");

  // right justified low byte carries the low eight bits
  right_word_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !I_EIGHT_BIT_MODE && !I_LEFT_JUSTIFY_SELECT
    |-> fmt_low == I_RAW[ARF_BYTE_WIDTH-1:0])
    else $error("right justified low byte wrong");

  // left justified low byte carries the two lowest bits on top
  left_top_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !I_EIGHT_BIT_MODE && I_LEFT_JUSTIFY_SELECT
    |-> fmt_low[ARF_BYTE_WIDTH-1:ARF_BYTE_WIDTH-ARF_SPILL] == I_RAW[ARF_SPILL-1:0])
    else $error("left justified low bits wrong");

  // left justified low byte is padded with zeros below
  left_pad_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !I_EIGHT_BIT_MODE && I_LEFT_JUSTIFY_SELECT
    |-> fmt_low[ARF_BYTE_WIDTH-ARF_SPILL-1:0] == ARF_ZERO_PAD)
    else $error("left justified pad not zero");

  // 8-bit mode low byte always zero
  eight_zero_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_EIGHT_BIT_MODE
    |-> fmt_low == ARF_ZERO_BYTE)
    else $error("8-bit low byte not zero");

  // ==========================================================
  // reset checks
  // high byte is clear at the first edge after release
  reset_high_a: assert property (@(posedge I_CLK)
    $rose(I_RST_B)
    |-> O_RESULT_HIGH == ARF_RESULT_RESET)
    else $error("high byte not clear after reset");

  // low byte is clear at the first edge after release
  reset_low_a: assert property (@(posedge I_CLK)
    $rose(I_RST_B)
    |-> O_RESULT_LOW == ARF_RESULT_RESET)
    else $error("low byte not clear after reset");
endmodule
`default_nettype wire

/* tb/arf_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module arf_core_model (
  input wire logic i_clk, // system clock
  output logic [9:0] o_raw = 10'h000, // raw result
  output logic o_done = 1'b0 // completion pulse
);
  // one-cycle completion; afterwards the stale word is inverted
  task automatic convert(input logic [9:0] r);
    o_raw <= r;
    o_done <= 1'b1;
    @(posedge i_clk);
    o_raw <= ~r;
    o_done <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/test_adc_result_word_formatter.sv */
`timescale 1ns/1ns
`default_nettype none
module test_adc_result_word_formatter;
  import arf_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, lj = 1'b0, m8 = 1'b0, wr = 1'b0, done;
  logic [7:0] addr = 8'h00, wd = 8'h5A, hi, lo;
  logic [9:0] raw;
  int n_errors = 0, compares = 0, cyc = 0;
  initial forever #10 clk = ~clk;
  arf_core_model u_arf_core_model (.i_clk(clk), .o_raw(raw), .o_done(done));
  arf_result_formatter u_arf_result_formatter (.I_CLK(clk), .I_RST_B(rst_b), .I_RAW(raw),
    .I_DONE(done), .I_LEFT_JUSTIFY_SELECT(lj), .I_EIGHT_BIT_MODE(m8), .I_SFR_WR(wr),
    .I_SFR_ADDR(addr), .I_SFR_WDATA(wd), .O_RESULT_HIGH(hi), .O_RESULT_LOW(lo));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one conversion, optionally with a colliding write that must lose
  task automatic conv(input logic [9:0] r, input logic l, input logic e, input logic w);
    @(posedge clk);
    lj <= l;
    m8 <= e;
    wr <= w;
    u_arf_core_model.convert(r);
    wr <= 1'b0;
    #1;
    chk(hi, e ? r[7:0] : (l ? r[9:2] : {6'h00, r[9:8]}));
    chk(lo, e ? 8'h00 : (l ? {r[1:0], 6'h00} : r[7:0]));
    $display("test conv %h done", r);
  endtask
  // a write touches one byte only; other addresses ignored
  task automatic wr_chk(input logic [7:0] a, input logic [7:0] eh, input logic [7:0] el);
    @(posedge clk);
    addr <= a;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
    chk(hi, eh);
    chk(lo, el);
    $display("test write %h done", a);
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 500) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk(hi, ARF_RESULT_RESET);
    chk(lo, ARF_RESULT_RESET);
    conv(10'h3FF, 1'b0, 1'b0, 1'b0);
    wr_chk(8'h00, 8'h03, 8'hFF);
    wr_chk(ARF_ADDR_RESULT_HIGH, 8'h5A, 8'hFF);
    wr_chk(ARF_ADDR_RESULT_LOW, 8'h5A, 8'h5A);
    conv(10'h2C5, 1'b1, 1'b0, 1'b1);
    conv(10'h1A6, 1'b1, 1'b1, 1'b0);
    conv(10'h159, 1'b0, 1'b1, 1'b1);
    conv(10'h203, 1'b0, 1'b0, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
